// ===== shared/pxc_cfg.svh
// Offsets, field positions, reset values and counts of the PLL and crystal oscillator control
`ifndef PXC_CFG_SVH
`define PXC_CFG_SVH
// ============================================================
// Register offsets (byte addresses)
`define PXC_OFF_CRYSTAL_OSCILLATOR_STATUS 8'h0c
`define PXC_OFF_CRYSTAL_OSCILLATOR_CTRL 8'h10
`define PXC_OFF_ULP_SYNC 8'h28
`define PXC_OFF_PLL_CTRLA 8'h2c
`define PXC_OFF_PLL_RATIO 8'h30
`define PXC_OFF_PLL_CTRLB 8'h34
`define PXC_OFF_PLL_PRESC 8'h38
`define PXC_OFF_PLL_SYNC 8'h3c
`define PXC_OFF_PLL_STATUS 8'h40
// ============================================================
// Field positions
`define PXC_BIT_ENABLE 1
`define PXC_BIT_RUN_IN_STANDBY 6
`define PXC_BIT_REQUEST_DRIVEN_RUN 7
`define PXC_BIT_WUF 3
`define PXC_BIT_LOCK_BYPASS 12
`define PXC_LOCK_TIME_SELECT_LSB 8
`define PXC_RATIO_FRAC_LSB 16
`define PXC_BIT_AUTO_GAIN_CONTROL 11
`define PXC_GAIN_LSB 8
`define PXC_STARTUP_LSB 12
`define PXC_BUSY_ENABLE 1
`define PXC_BUSY_RATIO 2
`define PXC_BUSY_PRESC 3
`define PXC_STAT_LOCK 0
`define PXC_STAT_CLOCK_READY_FLAG 1
`define PXC_STAT_XOSCRDY 0
// ============================================================
// Writable masks and reset values
`define PXC_MASK_CTRLA 32'h0000_00c2
`define PXC_MASK_RATIO 32'h000f_0fff
`define PXC_MASK_CTRLB 32'h07ff_173f
`define PXC_MASK_PRESC 32'h0000_0003
`define PXC_MASK_CRYSTAL_OSCILLATOR 32'h0000_ffc2
`define PXC_RST_REG 32'h0000_0000
// ============================================================
// Counts
`define PXC_SYNC_CYC 4'h3
`define PXC_XTAL_EDGES 2'h3
`define PXC_LOCK_STEP 8
`endif

// ===== shared/pxc_pkg.sv
// Types of the PLL and crystal oscillator control
package pxc_pkg;
    typedef enum logic [1:0] {
        PLL_OFF = 2'b00,
        PLL_START = 2'b01,
        PLL_ACQ = 2'b10,
        PLL_RUN = 2'b11
    } pxc_pll_state_t;
    typedef enum logic [1:0] {
        XO_OFF = 2'b00,
        XO_XTAL = 2'b01,
        XO_ULP = 2'b10,
        XO_READY = 2'b11
    } pxc_xo_state_t;
endpackage

// ===== verilog/pxc_pll_osc_ctrl.sv
// PLL and crystal oscillator control with register port
`timescale 1ns/100ps
`include "pxc_cfg.svh"
// What this block does
// - Enable bit starts and stops the PLL
// - Enable change sets busy, cleared when running
// - Disable keeps busy until output clock stops
// - Lock flag only while enabled and locked
// - Non-zero lock time validates lock by timer
// - Zero lock time follows loop lock status
// - Fast wakeup opens gate after startup
// - Lock bypass decides gate after acquisition
// - First output edge per mode table
// - Ratio is integer plus one plus fraction/16
// - Byte, halfword and word accesses supported
// - Protected writes ignored except from debugger
// - Synchronized registers report progress in busy
// - Startup counts three crystal edges, then two-to-code slow cycles
// - Auto gain adjusts while crystal runs
// - On-demand runs oscillator only when requested
// - Else runs outside standby; in standby only with run-in-standby set
module pxc_pll_osc_ctrl #(
    parameter int LOCK_STEP = `PXC_LOCK_STEP
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic [3:0] regByteEn,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    // Access protection
    input wire logic protectEn,
    input wire logic debugAccess,
    // System state and clock requests
    input wire logic standbyMode,
    input wire logic pllRequest,
    input wire logic xoscRequest,
    // PLL analog side
    input wire logic pllCkActive,
    input wire logic pllLoopLock,
    input wire logic lockCountClk,
    output logic pllAnalogEn,
    output logic pllGateEn,
    output logic [12:0] pllMultInt,
    output logic [3:0] pllMultFrac,
    output logic [1:0] pllPrescale,
    output logic [25:0] pllCtrlB,
    // Crystal oscillator analog side
    input wire logic ulpSlowClk,
    input wire logic xoscClk,
    output logic xoscAnalogEn,
    output logic [2:0] xoscGain,
    output logic xoscAutoGainEn
);
    // ============================================================
    // Register storage
    logic [31:0] ctrlA_q, ratio_q, ctrlB_q, presc_q, xoscCtrl_q;
    logic enBusy_q, ratioBusy_q, prescBusy_q, lockFlag_q, xoscReady_q;
    logic [3:0] ratioCnt_q, prescCnt_q;
    pxc_pkg::pxc_pll_state_t pllState_q, pllState_d;
    pxc_pkg::pxc_xo_state_t xoState_q;
    logic [10:0] lockTimer_q;
    logic [15:0] ulpCnt_q;
    logic [1:0] xtalCnt_q;
    logic lockClkPrev_q, ulpPrev_q, xtalPrev_q;

    // Merge byte lanes so narrow accesses touch only their own bytes
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldV, input logic [31:0] newV,
                                                input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
        mergeBytes = (oldV & ~m) | (newV & m);
    endfunction

    // ============================================================
    // Write decode
    logic wrOk, wrCtrlA, wrRatio, wrCtrlB, wrPresc, wrXosc;
    logic [31:0] ctrlANew;
    assign wrOk = regWrite && (!protectEn || debugAccess);
    assign wrCtrlA = wrOk && regAddr == `PXC_OFF_PLL_CTRLA;
    assign wrRatio = wrOk && regAddr == `PXC_OFF_PLL_RATIO;
    assign wrCtrlB = wrOk && regAddr == `PXC_OFF_PLL_CTRLB;
    assign wrPresc = wrOk && regAddr == `PXC_OFF_PLL_PRESC;
    assign wrXosc = wrOk && regAddr == `PXC_OFF_CRYSTAL_OSCILLATOR_CTRL;
    assign ctrlANew = mergeBytes(ctrlA_q, regWrData, regByteEn, `PXC_MASK_CTRLA);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlA_q <= `PXC_RST_REG;
            ratio_q <= `PXC_RST_REG;
            ctrlB_q <= `PXC_RST_REG;
            presc_q <= `PXC_RST_REG;
            xoscCtrl_q <= `PXC_RST_REG;
        end else begin
            if (wrCtrlA) begin
                ctrlA_q <= ctrlANew;
            end
            if (wrRatio) begin
                ratio_q <= mergeBytes(ratio_q, regWrData, regByteEn, `PXC_MASK_RATIO);
            end
            if (wrCtrlB) begin
                ctrlB_q <= mergeBytes(ctrlB_q, regWrData, regByteEn, `PXC_MASK_CTRLB);
            end
            if (wrPresc) begin
                presc_q <= mergeBytes(presc_q, regWrData, regByteEn, `PXC_MASK_PRESC);
            end
            if (wrXosc) begin
                xoscCtrl_q <= mergeBytes(xoscCtrl_q, regWrData, regByteEn, `PXC_MASK_CRYSTAL_OSCILLATOR);
            end
        end
    end

    // ============================================================
    // Run gating from enable, on-demand requests and standby
    logic pllRun, xoscRun, pllEnable;
    logic [2:0] lockTime;
    assign pllEnable = ctrlA_q[`PXC_BIT_ENABLE];
    assign lockTime = ctrlB_q[`PXC_LOCK_TIME_SELECT_LSB +: 3];
    assign pllRun = pllEnable && (ctrlA_q[`PXC_BIT_REQUEST_DRIVEN_RUN] ? pllRequest
                                  : (!standbyMode || ctrlA_q[`PXC_BIT_RUN_IN_STANDBY]));
    assign xoscRun = xoscCtrl_q[`PXC_BIT_ENABLE] && (xoscCtrl_q[`PXC_BIT_REQUEST_DRIVEN_RUN] ? xoscRequest
                                  : (!standbyMode || xoscCtrl_q[`PXC_BIT_RUN_IN_STANDBY]));

    // ============================================================
    // Synchronization busy flags; a new event beats a clear
    logic enToggle;
    assign enToggle = wrCtrlA && (ctrlANew[`PXC_BIT_ENABLE] != pllEnable);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enBusy_q <= 1'b0;
        end else if (enToggle) begin
            enBusy_q <= 1'b1;
        end else if (pllEnable && (pllCkActive || !pllRun)) begin
            // On-demand with no request never starts the clock, so do not hang busy
            enBusy_q <= 1'b0;
        end else if (!pllEnable && !pllCkActive) begin
            enBusy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ratioBusy_q <= 1'b0;
            ratioCnt_q <= 4'h0;
            pllMultInt <= 13'h0001;
            pllMultFrac <= 4'h0;
        end else if (wrRatio) begin
            ratioBusy_q <= 1'b1;
            ratioCnt_q <= `PXC_SYNC_CYC;
        end else if (ratioBusy_q) begin
            ratioCnt_q <= ratioCnt_q - 4'h1;
            if (ratioCnt_q == 4'h1) begin
                ratioBusy_q <= 1'b0;
                pllMultInt <= {1'b0, ratio_q[11:0]} + 13'h0001;
                pllMultFrac <= ratio_q[`PXC_RATIO_FRAC_LSB +: 4];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prescBusy_q <= 1'b0;
            prescCnt_q <= 4'h0;
            pllPrescale <= 2'h0;
        end else if (wrPresc) begin
            prescBusy_q <= 1'b1;
            prescCnt_q <= `PXC_SYNC_CYC;
        end else if (prescBusy_q) begin
            prescCnt_q <= prescCnt_q - 4'h1;
            if (prescCnt_q == 4'h1) begin
                prescBusy_q <= 1'b0;
                pllPrescale <= presc_q[1:0];
            end
        end
    end

    // ============================================================
    // Lock count clock tick and lock timer
    logic lockTick, timerDone, lockNow;
    assign lockTick = lockCountClk && !lockClkPrev_q;
    assign timerDone = lockTimer_q == 11'h000;
    assign lockNow = (lockTime == 3'h0) ? pllLoopLock : timerDone;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lockClkPrev_q <= 1'b0;
            lockTimer_q <= 11'h000;
        end else begin
            lockClkPrev_q <= lockCountClk;
            if (pllState_q == pxc_pkg::PLL_START) begin
                // Constant lock time counted on the 32 kHz tick
                lockTimer_q <= 11'(int'(lockTime) * LOCK_STEP);
            end else if (pllState_q == pxc_pkg::PLL_ACQ && lockTick && !timerDone) begin
                lockTimer_q <= lockTimer_q - 11'h001;
            end
        end
    end

    // ============================================================
    // PLL sequence: startup, acquisition, running
    always_comb begin
        pllState_d = pllState_q;
        unique case (pllState_q)
            pxc_pkg::PLL_OFF: begin
                if (pllRun) begin
                    pllState_d = pxc_pkg::PLL_START;
                end
            end
            pxc_pkg::PLL_START: begin
                if (!pllRun) begin
                    pllState_d = pxc_pkg::PLL_OFF;
                end else if (pllCkActive) begin
                    pllState_d = pxc_pkg::PLL_ACQ;
                end
            end
            pxc_pkg::PLL_ACQ: begin
                if (!pllRun) begin
                    pllState_d = pxc_pkg::PLL_OFF;
                end else if (lockNow) begin
                    pllState_d = pxc_pkg::PLL_RUN;
                end
            end
            pxc_pkg::PLL_RUN: begin
                if (!pllRun) begin
                    pllState_d = pxc_pkg::PLL_OFF;
                end else if (!pllCkActive) begin
                    pllState_d = pxc_pkg::PLL_START;
                end
            end
        endcase
    end

    logic lockFlag_d, gate_d, inLockPhase;
    assign inLockPhase = pllState_q == pxc_pkg::PLL_ACQ || pllState_q == pxc_pkg::PLL_RUN;
    assign lockFlag_d = pllRun && pllEnable && inLockPhase && lockNow;
    // During acquisition fast wakeup or lock opens the gate; once running, bypass or lock
    assign gate_d = pllRun && pllCkActive &&
                    ((pllState_q == pxc_pkg::PLL_ACQ && ctrlB_q[`PXC_BIT_WUF]) ||
                     (pllState_q == pxc_pkg::PLL_ACQ && lockNow) ||
                     (pllState_q == pxc_pkg::PLL_RUN &&
                      (ctrlB_q[`PXC_BIT_LOCK_BYPASS] || lockNow)));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pllState_q <= pxc_pkg::PLL_OFF;
            lockFlag_q <= 1'b0;
            pllGateEn <= 1'b0;
            pllAnalogEn <= 1'b0;
            pllCtrlB <= 26'h0;
        end else begin
            pllState_q <= pllState_d;
            lockFlag_q <= lockFlag_d;
            pllGateEn <= gate_d;
            pllAnalogEn <= pllRun;
            pllCtrlB <= ctrlB_q[25:0];
        end
    end

    // ============================================================
    // Crystal startup: three crystal edges, then 2^code slow cycles
    logic ulpTick, xtalTick;
    logic [15:0] startupCount;
    assign ulpTick = ulpSlowClk && !ulpPrev_q;
    assign xtalTick = xoscClk && !xtalPrev_q;
    assign startupCount = 16'h0001 << xoscCtrl_q[`PXC_STARTUP_LSB +: 4];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xoState_q <= pxc_pkg::XO_OFF;
            ulpPrev_q <= 1'b0;
            xtalPrev_q <= 1'b0;
            ulpCnt_q <= 16'h0000;
            xtalCnt_q <= 2'h0;
            xoscReady_q <= 1'b0;
            xoscAnalogEn <= 1'b0;
            xoscGain <= 3'h0;
            xoscAutoGainEn <= 1'b0;
        end else begin
            ulpPrev_q <= ulpSlowClk;
            xoscAnalogEn <= xoscRun;
            // Gain field still drives the core, auto gain trims around it
            xoscGain <= xoscCtrl_q[`PXC_GAIN_LSB +: 3];
            xoscAutoGainEn <= xoscCtrl_q[`PXC_BIT_AUTO_GAIN_CONTROL] && xoscRun;
            xtalPrev_q <= xoscClk;
            xoscReady_q <= xoState_q == pxc_pkg::XO_READY && xoscRun;
            if (!xoscRun) begin
                xoState_q <= pxc_pkg::XO_OFF;
            end else begin
                unique case (xoState_q)
                    pxc_pkg::XO_OFF: begin
                        xoState_q <= pxc_pkg::XO_XTAL;
                        xtalCnt_q <= `PXC_XTAL_EDGES;
                    end
                    pxc_pkg::XO_XTAL: begin
                        if (xtalTick) begin
                            xtalCnt_q <= xtalCnt_q - 2'h1;
                            if (xtalCnt_q == 2'h1) begin
                                xoState_q <= pxc_pkg::XO_ULP;
                                ulpCnt_q <= startupCount;
                            end
                        end
                    end
                    pxc_pkg::XO_ULP: begin
                        if (ulpTick) begin
                            ulpCnt_q <= ulpCnt_q - 16'h0001;
                            if (ulpCnt_q == 16'h0001) begin
                                xoState_q <= pxc_pkg::XO_READY;
                            end
                        end
                    end
                    pxc_pkg::XO_READY: begin
                        xoState_q <= pxc_pkg::XO_READY;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Read port, data in the cycle after the strobe
    logic [31:0] rdMux, syncWord, statWord;
    always_comb begin
        syncWord = 32'h0;
        syncWord[`PXC_BUSY_ENABLE] = enBusy_q;
        syncWord[`PXC_BUSY_RATIO] = ratioBusy_q;
        syncWord[`PXC_BUSY_PRESC] = prescBusy_q;
        statWord = 32'h0;
        statWord[`PXC_STAT_LOCK] = lockFlag_q;
        statWord[`PXC_STAT_CLOCK_READY_FLAG] = pllGateEn;
        unique case (regAddr)
            `PXC_OFF_CRYSTAL_OSCILLATOR_STATUS: rdMux = {31'h0, xoscReady_q};
            `PXC_OFF_CRYSTAL_OSCILLATOR_CTRL: rdMux = xoscCtrl_q;
            `PXC_OFF_PLL_CTRLA: rdMux = ctrlA_q;
            `PXC_OFF_PLL_RATIO: rdMux = ratio_q;
            `PXC_OFF_PLL_CTRLB: rdMux = ctrlB_q;
            `PXC_OFF_PLL_PRESC: rdMux = presc_q;
            `PXC_OFF_PLL_SYNC: rdMux = syncWord;
            `PXC_OFF_PLL_STATUS: rdMux = statWord;
            default: rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 32'h0;
        end else if (regRead) begin
            // Unused byte lanes read zero for narrow reads
            regRdData <= rdMux & {{8{regByteEn[3]}}, {8{regByteEn[2]}},
                                  {8{regByteEn[1]}}, {8{regByteEn[0]}}};
        end else begin
            regRdData <= 32'h0;
        end
    end
endmodule

// ===== dv/pxc_pll_osc_ctrl_sva.sv
// Port checks of the PLL and crystal oscillator control
`timescale 1ns/100ps
module pxc_pll_osc_ctrl_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdData,
    // PLL side
    input wire logic pllCkActive,
    input wire logic pllAnalogEn,
    input wire logic pllGateEn,
    input wire logic [12:0] pllMultInt,
    input wire logic [1:0] pllPrescale,
    // Crystal side
    input wire logic xoscAnalogEn,
    input wire logic xoscAutoGainEn
);
    // ==========================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    read_idle_a: assert property (!regRead |=> regRdData == 32'h0)
        else $error("read data outside answer cycle");
    ulp_zero_a: assert property (regRead && regAddr == 8'h28 |=> regRdData == 32'h0)
        else $error("slow loop sync word not zero");
    gate_run_a: assert property (pllGateEn |-> pllAnalogEn)
        else $error("gate open while PLL off");
    gate_ck_a: assert property (!pllCkActive |=> !pllGateEn)
        else $error("gate open without output clock");
    mult_floor_a: assert property (pllMultInt != 13'h0)
        else $error("ratio below one");
    // Outputs may only move once the sync delay after a write has run out
    ratio_sync_a: assert property ($changed(pllMultInt) |-> $past(regWrite, 4) && $past(regAddr, 4) == 8'h30)
        else $error("ratio applied without sync delay");
    presc_sync_a: assert property ($changed(pllPrescale) |-> $past(regWrite, 4) && $past(regAddr, 4) == 8'h38)
        else $error("prescaler applied without sync delay");
    gain_run_a: assert property (xoscAutoGainEn |-> xoscAnalogEn)
        else $error("auto gain while crystal off");
endmodule

// ===== dv/pxc_analog_model.sv
// Behavioural analog side: PLL core, crystal and slow clocks
`timescale 1ns/100ps
module pxc_analog_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Controls
    input wire logic pllAnalogEn,
    input wire logic xoscAnalogEn,
    input wire logic loseLock,
    // Status and clocks
    output logic pllCkActive,
    output logic pllLoopLock,
    output logic lockCountClk,
    output logic ulpSlowClk,
    output logic xoscClk
);
    // ==========================================
    // PLL core
    logic [1:0] ckDly_q;
    logic [5:0] lockCnt_q;
    logic tick_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ckDly_q <= 2'h0;
            lockCnt_q <= 6'h00;
        end else begin
            ckDly_q <= {ckDly_q[0], pllAnalogEn};
            if (!ckDly_q[1]) begin
                lockCnt_q <= 6'h00;
            end else if (lockCnt_q != 6'h3f) begin
                lockCnt_q <= lockCnt_q + 6'h01;
            end
        end
    end
    assign pllCkActive = ckDly_q[1];
    // Loop locks late so that the lock timer always wins
    assign pllLoopLock = (lockCnt_q > 6'h28) && !loseLock;
    // ==========================================
    // Slow clocks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= !tick_q;
        end
    end
    assign lockCountClk = tick_q;
    assign ulpSlowClk = tick_q;
    // Crystal stands still while powered down
    assign xoscClk = tick_q && xoscAnalogEn;
endmodule

// ===== dv/pxc_pll_osc_ctrl_bench.sv
// Self-checking bench of the PLL and crystal oscillator control
`timescale 1ns/100ps
module pxc_pll_osc_ctrl_bench;
    // ==========================================
    // Signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic [3:0] regByteEn = 4'h0;
    logic regWrite = 1'b0, regRead = 1'b0, protectEn = 1'b0, debugAccess = 1'b0;
    logic standbyMode = 1'b0, pllRequest = 1'b0, xoscRequest = 1'b0, loseLock = 1'b0;
    logic [31:0] regRdData;
    logic [12:0] pllMultInt;
    logic [3:0] pllMultFrac;
    logic [1:0] pllPrescale;
    logic [25:0] pllCtrlB;
    logic [2:0] xoscGain;
    logic pllCkActive, pllLoopLock, lockCountClk, ulpSlowClk, xoscClk;
    logic pllAnalogEn, pllGateEn, xoscAnalogEn, xoscAutoGainEn;
    int numErrors = 0;
    int checked = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    pxc_pll_osc_ctrl #(.LOCK_STEP(1)) dut (
        .clk, .reset_n, .regAddr, .regWrData, .regByteEn, .regWrite, .regRead, .regRdData,
        .protectEn, .debugAccess, .standbyMode, .pllRequest, .xoscRequest, .pllCkActive,
        .pllLoopLock, .lockCountClk, .pllAnalogEn, .pllGateEn, .pllMultInt, .pllMultFrac,
        .pllPrescale, .pllCtrlB, .ulpSlowClk, .xoscClk, .xoscAnalogEn, .xoscGain, .xoscAutoGainEn
    );
    pxc_analog_model model (
        .clk, .reset_n, .pllAnalogEn, .xoscAnalogEn, .loseLock,
        .pllCkActive, .pllLoopLock, .lockCountClk, .ulpSlowClk, .xoscClk
    );
    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regByteEn <= be;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regByteEn <= 4'hf;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        check(regRdData, exp);
    endtask
    task automatic pllOn();
        wr(8'h2c, 32'h2, 4'h1);
        repeat (300) if (!pllGateEn) tick(1);
    endtask
    task automatic pllOff();
        wr(8'h2c, 32'h0, 4'h1);
        tick(10);
    endtask
    // ==========================================
    // Scenarios
    task automatic tReset();
        logic [7:0] offs [10] = '{8'h0c, 8'h10, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44};
        foreach (offs[i]) rd(offs[i], 32'h0);
        check({19'h0, pllMultInt}, 32'h1);
    endtask
    task automatic tRatio();
        wr(8'h30, 32'h0003_05db, 4'hf);
        rd(8'h3c, 32'h4);
        tick(3);
        check({15'h0, pllMultFrac, pllMultInt}, {15'h0, 4'h3, 13'd1500});
        wr(8'h30, 32'hffff_ffff, 4'h2);
        rd(8'h30, 32'h0003_0fdb);
        tick(3);
        check({19'h0, pllMultInt}, 32'hfdc);
        rd(8'h3c, 32'h0);
    endtask
    task automatic tProtect();
        @(posedge clk);
        protectEn <= 1'b1;
        wr(8'h38, 32'h3, 4'h1);
        rd(8'h38, 32'h0);
        @(posedge clk);
        debugAccess <= 1'b1;
        wr(8'h38, 32'h3, 4'h1);
        debugAccess <= 1'b0;
        protectEn <= 1'b0;
        rd(8'h3c, 32'h8);
        tick(3);
        check({30'h0, pllPrescale}, 32'h3);
    endtask
    task automatic tNormal();
        wr(8'h34, 32'h0, 4'hf);
        wr(8'h2c, 32'h2, 4'h1);
        rd(8'h3c, 32'h2);
        repeat (300) if (!pllGateEn) tick(1);
        check({pllGateEn, pllLoopLock}, 2'b11);
        rd(8'h40, 32'h3);
        rd(8'h3c, 32'h0);
        @(posedge clk);
        loseLock <= 1'b1;
        tick(3);
        check(pllGateEn, 1'b0);
        wr(8'h34, 32'h1000, 4'h2);
        tick(3);
        check({pllGateEn, 5'h0, pllCtrlB}, 32'h8000_1000);
        @(posedge clk);
        loseLock <= 1'b0;
        wr(8'h2c, 32'h0, 4'h1);
        rd(8'h3c, 32'h2);
        tick(10);
        rd(8'h3c, 32'h0);
        check(pllGateEn, 1'b0);
    endtask
    task automatic tModes();
        wr(8'h34, 32'h200, 4'hf);
        pllOn();
        check({pllGateEn, pllLoopLock}, 2'b10);
        rd(8'h40, 32'h3);
        pllOff();
        wr(8'h34, 32'h8, 4'hf);
        pllOn();
        check({pllGateEn, pllLoopLock}, 2'b10);
        rd(8'h40, 32'h2);
        pllOff();
    endtask
    task automatic tDemand();
        wr(8'h2c, 32'h82, 4'h1);
        tick(5);
        check(pllAnalogEn, 1'b0);
        @(posedge clk);
        pllRequest <= 1'b1;
        standbyMode <= 1'b1;
        tick(3);
        check(pllAnalogEn, 1'b1);
        @(posedge clk);
        pllRequest <= 1'b0;
        tick(3);
        check(pllAnalogEn, 1'b0);
        wr(8'h2c, 32'h2, 4'h1);
        tick(3);
        check(pllAnalogEn, 1'b0);
        wr(8'h2c, 32'h42, 4'h1);
        tick(3);
        check(pllAnalogEn, 1'b1);
        @(posedge clk);
        standbyMode <= 1'b0;
        pllOff();
    endtask
    task automatic tCrystal();
        wr(8'h10, 32'h2302, 4'hf);
        tick(10);
        rd(8'h0c, 32'h0);
        tick(40);
        rd(8'h0c, 32'h1);
        wr(8'h10, 32'h2b02, 4'hf);
        tick(2);
        check({xoscAutoGainEn, xoscGain}, 4'hb);
        wr(8'h10, 32'h0, 4'hf);
        tick(2);
        check({xoscAutoGainEn, xoscAnalogEn}, 2'b00);
        rd(8'h0c, 32'h0);
        wr(8'h10, 32'h0082, 4'hf);
        tick(2);
        check(xoscAnalogEn, 1'b0);
        @(posedge clk);
        xoscRequest <= 1'b1;
        tick(2);
        check(xoscAnalogEn, 1'b1);
        @(posedge clk);
        xoscRequest <= 1'b0;
        tick(2);
        check(xoscAnalogEn, 1'b0);
        wr(8'h10, 32'h0, 4'hf);
    endtask
    // ==========================================
    // Sequence and verdict
    task automatic giveVerdict();
        if (numErrors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            numErrors++;
            giveVerdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        tReset();
        tRatio();
        tProtect();
        tNormal();
        tModes();
        tDemand();
        tCrystal();
        giveVerdict();
    end
endmodule
bind pxc_pll_osc_ctrl pxc_pll_osc_ctrl_sva chk (
    .clk, .reset_n, .regAddr, .regWrite, .regRead, .regRdData, .pllCkActive,
    .pllAnalogEn, .pllGateEn, .pllMultInt, .pllPrescale, .xoscAnalogEn, .xoscAutoGainEn
);
